// File: core/scan_pkg.sv
package scan_pkg;

	// ------------------------------------------------------------
	// Scan geometry
	// ------------------------------------------------------------
	localparam int NUM_PIXELS = 2048;
	localparam int FIRST_VALID_STROBE = 89;
	localparam int FULL_SCAN_CLK = 2140;
	localparam int PIX_WIDTH = 12;

	// ------------------------------------------------------------
	// Start pulse limits and integration tail, in sensor clock periods
	// ------------------------------------------------------------
	localparam int MIN_PERIOD_CLK = 98;
	localparam int MIN_HIGH_CLK = 6;
	localparam int MIN_LOW_CLK = 92;
	localparam int INTEG_TAIL_CLK = 48;

	// ------------------------------------------------------------
	// Clock rates
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ = 25_000_000;
	localparam int MAX_SENSOR_HZ = 10_000_000;
	localparam int SENSOR_DIV = 4;

	// ------------------------------------------------------------
	// Controller defaults after reset, in sensor clock periods
	// ------------------------------------------------------------
	localparam logic [15:0] RST_PERIOD = 16'h085c;
	localparam logic [15:0] RST_HIGH = 16'h0800;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		INT_IDLE,
		INT_HIGH,
		INT_TAIL
	} integ_state_type;

endpackage

// File: core/sensor_link_if.sv
`timescale 1ns/1ps

// Wires between the line sensor and its controller
interface sensor_link_if #(
	parameter int PIX_W = scan_pkg::PIX_WIDTH
);
	logic sclk;
	logic scan_start_pulse;
	logic [PIX_W-1:0] video;
	logic trig;
	logic scan_done_flag;

	modport sensor_end (
		input sclk,
		input scan_start_pulse,
		output video,
		output trig,
		output scan_done_flag
	);

	modport ctrl_end (
		output sclk,
		output scan_start_pulse,
		input video,
		input trig,
		input scan_done_flag
	);
endinterface

// File: core/exposure_well.sv
`timescale 1ns/1ps

// Shared charge well: one level for every pixel, saturating
module exposure_well #(
	parameter int PIX_W = scan_pkg::PIX_WIDTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic clear_i,
	input wire logic add_i,
	input wire logic [PIX_W-1:0] illum_i,
	// Level
	output logic [PIX_W-1:0] level_o
);
	logic [PIX_W-1:0] level_r;
	logic [PIX_W-1:0] level_nxt;
	logic [PIX_W:0] sum;

	// Accumulate light, clip at full well
	always_comb begin
		sum = {1'b0, level_r} + {1'b0, illum_i};
		level_nxt = level_r;
		if (clear_i) begin
			level_nxt = '0;
		end else if (add_i) begin
			level_nxt = sum[PIX_W] ? '1 : sum[PIX_W-1:0];
		end
	end

	// Register the well
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_r <= '0;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign level_o = level_r;
endmodule

// File: core/line_sensor_end.sv
`timescale 1ns/1ps

// Sensor end: timing generator, shared integration, serial readout
module line_sensor_end #(
	parameter int PIX_W = scan_pkg::PIX_WIDTH,
	parameter int NUM_PIX = scan_pkg::NUM_PIXELS
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Link to the controller
	sensor_link_if.sensor_end LINK,
	// Scene
	input wire logic [PIX_W-1:0] ILLUM_I,
	// Status
	output logic INTEG_O,
	output logic [15:0] EXPOSURE_CLK_O
);
	localparam int LAST_CNT = scan_pkg::FIRST_VALID_STROBE + NUM_PIX - 1;
	localparam int CNT_W = $clog2(LAST_CNT + 1);
	localparam logic [CNT_W-1:0] FIRST_C =
		CNT_W'(scan_pkg::FIRST_VALID_STROBE);
	localparam logic [CNT_W-1:0] LAST_C = CNT_W'(LAST_CNT);
	localparam logic [5:0] TAIL_C = 6'(scan_pkg::INTEG_TAIL_CLK);

	initial begin
		if (NUM_PIX < 1 || PIX_W < 1) begin
			$error("line_sensor_end: bad geometry");
		end
	end

	// ------------------------------------------------------------
	// Clock edge and start pulse sampling
	// ------------------------------------------------------------
	logic clk_q_r, st_q_r, st_q_nxt;
	logic rise, fall, st_up, st_dn;

	assign rise = LINK.sclk & ~clk_q_r;
	assign fall = ~LINK.sclk & clk_q_r;
	assign st_up = rise & LINK.scan_start_pulse & ~st_q_r;
	assign st_dn = rise & ~LINK.scan_start_pulse & st_q_r;

	// Start pulse is taken on sensor clock rises only
	always_comb begin
		st_q_nxt = rise ? LINK.scan_start_pulse : st_q_r;
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			clk_q_r <= 1'b0;
			st_q_r <= 1'b0;
		end else begin
			clk_q_r <= LINK.sclk;
			st_q_r <= st_q_nxt;
		end
	end

	// ------------------------------------------------------------
	// Integration window, common to all pixels
	// ------------------------------------------------------------
	scan_pkg::integ_state_type int_r, int_nxt;
	logic [5:0] tail_r, tail_nxt;
	logic [15:0] exp_r, exp_nxt, last_exp_r, last_exp_nxt;
	logic [PIX_W-1:0] frame_r, frame_nxt, level;
	logic integ_r, integ_nxt;

	// High time plus a fixed tail, then freeze the well
	always_comb begin
		int_nxt = int_r;
		tail_nxt = tail_r;
		exp_nxt = exp_r;
		last_exp_nxt = last_exp_r;
		frame_nxt = frame_r;
		if (st_up) begin
			int_nxt = scan_pkg::INT_HIGH;
			exp_nxt = '0;
		end else if (rise) begin
			unique case (int_r)
				scan_pkg::INT_IDLE: begin
				end
				scan_pkg::INT_HIGH: begin
					exp_nxt = exp_r + 16'h0001;
					if (st_dn) begin
						int_nxt = scan_pkg::INT_TAIL; // RL5
						tail_nxt = 6'h00;
					end
				end
				scan_pkg::INT_TAIL: begin
					exp_nxt = exp_r + 16'h0001;
					tail_nxt = tail_r + 6'h01;
					if (tail_r == TAIL_C - 6'h01) begin
						int_nxt = scan_pkg::INT_IDLE; // RL5
						frame_nxt = level; // RL14
						last_exp_nxt = exp_r + 16'h0001;
					end
				end
			endcase
		end
		integ_nxt = (int_nxt != scan_pkg::INT_IDLE);
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			int_r <= scan_pkg::INT_IDLE;
			tail_r <= 6'h00;
			exp_r <= 16'h0000;
			last_exp_r <= 16'h0000;
			frame_r <= '0;
			integ_r <= 1'b0;
		end else begin
			int_r <= int_nxt;
			tail_r <= tail_nxt;
			exp_r <= exp_nxt;
			last_exp_r <= last_exp_nxt;
			frame_r <= frame_nxt;
			integ_r <= integ_nxt;
		end
	end

	// One well serves every pixel at once
	exposure_well #(
		.PIX_W(PIX_W)
	) u_well (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.clear_i(st_up), // RL14
		.add_i(rise && int_r != scan_pkg::INT_IDLE),
		.illum_i(ILLUM_I),
		.level_o(level)
	);

	// ------------------------------------------------------------
	// Readout shift counter, strobe and end of scan
	// ------------------------------------------------------------
	logic run_r, run_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [PIX_W-1:0] video_r, video_nxt;
	logic trig_r, trig_nxt, done_r, done_nxt;

	// One pixel per sensor clock, first valid at strobe FIRST_C
	always_comb begin
		run_nxt = run_r;
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		if (rise) begin
			done_nxt = 1'b0;
			if (st_dn) begin
				run_nxt = 1'b1; // RL4
				cnt_nxt = {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (run_r) begin
				if (cnt_r == LAST_C) begin
					run_nxt = 1'b0;
					done_nxt = 1'b1; // RL15
				end else begin
					cnt_nxt = cnt_r + 1'b1; // RL11
				end
			end
		end
		video_nxt = video_r;
		if (rise) begin
			video_nxt = (run_nxt && cnt_nxt >= FIRST_C) ? frame_r : '0; // RL7
		end
		trig_nxt = trig_r;
		if (fall) begin
			trig_nxt = run_r; // RL9
		end else if (rise) begin
			trig_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			run_r <= 1'b0;
			cnt_r <= '0;
			video_r <= '0;
			trig_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
			video_r <= video_nxt;
			trig_r <= trig_nxt;
			done_r <= done_nxt;
		end
	end

	// Only clock and start come in; all timing is local
	assign LINK.video = video_r; // RL13
	assign LINK.trig = trig_r;
	assign LINK.scan_done_flag = done_r;
	assign INTEG_O = integ_r;
	assign EXPOSURE_CLK_O = last_exp_r;
endmodule

// File: core/scan_controller_end.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Overview of operation
// [RL1] Start rises at least 98 clocks apart
// [RL2] Start high at least 6 clocks
// [RL3] Start low at least 92 clocks
// [RL4] Shift begins first clock rise after start falls
// [RL5] Integration is high time plus 48 clocks
// [RL6] High time sets exposure
// [RL7] First valid pixel at strobe 89
// [RL8] Controller samples video on strobe rise
// [RL9] Sensor drives a per-pixel sample strobe
// [RL10] Full readout needs period of 2140 clocks
// [RL11] One pixel per clock, clock up to 10 MHz
// [RL12] Keep period and high time short
// [RL13] Sensor needs only clock and start
// [RL14] All pixels integrate over one window
// [RL15] End-of-scan flag after last pixel shifted
// ------------------------------------------------------------

// Controller end: clock divider, start pulse, pixel capture
module scan_controller_end #(
	parameter int PIX_W = scan_pkg::PIX_WIDTH,
	parameter int NUM_PIX = scan_pkg::NUM_PIXELS,
	parameter int DIV = scan_pkg::SENSOR_DIV
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Link to the sensor
	sensor_link_if.ctrl_end LINK,
	// Scan settings, in sensor clock periods
	input wire logic RUN_I,
	input wire logic [15:0] PERIOD_I,
	input wire logic [15:0] HIGH_I,
	// Captured pixels
	output logic PIX_VALID_O,
	output logic [PIX_W-1:0] PIX_DATA_O,
	output logic [15:0] PIX_INDEX_O,
	output logic FRAME_DONE_O,
	// Status
	output logic FULL_SCAN_O,
	output logic ADJUSTED_O
);
	localparam int DIV_W = $clog2(DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
	localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV / 2);
	localparam logic [15:0] MIN_HIGH = 16'(scan_pkg::MIN_HIGH_CLK);
	localparam logic [15:0] MIN_LOW = 16'(scan_pkg::MIN_LOW_CLK);
	localparam logic [15:0] MIN_PER = 16'(scan_pkg::MIN_PERIOD_CLK);
	localparam logic [15:0] FULL_PER = 16'(scan_pkg::FULL_SCAN_CLK);
	localparam logic [15:0] FIRST_S = 16'(scan_pkg::FIRST_VALID_STROBE);
	localparam logic [15:0] NPIX = 16'(NUM_PIX);

	// Divider must keep even duty, the clock under its limit and
	// leave room for the strobe round trip
	initial begin
		if (DIV < 4 || DIV % 2 != 0 ||
			scan_pkg::SYS_CLK_HZ / DIV > scan_pkg::MAX_SENSOR_HZ) begin
			$error("scan_controller_end: DIV unusable");
		end
		if (NUM_PIX < 1 || NUM_PIX > 65535) begin
			$error("scan_controller_end: NUM_PIX unusable");
		end
	end

	// Clamp a request up to a floor
	function automatic logic [15:0] at_least(input logic [15:0] v,
		input logic [15:0] floor_v);
		at_least = (v < floor_v) ? floor_v : v;
	endfunction

	// ------------------------------------------------------------
	// Sensor clock divider
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_r, div_nxt;
	logic sclk_r, sclk_nxt;
	logic sclk_rise, sclk_fall;

	// Free running square wave, half of DIV high
	always_comb begin
		div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
		sclk_nxt = (div_nxt < DIV_HALF); // RL11
		sclk_rise = (div_r == DIV_LAST);
		sclk_fall = (div_r == DIV_HALF - 1'b1);
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			div_r <= DIV_HALF; // Phase that matches sclk low
			sclk_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			sclk_r <= sclk_nxt;
		end
	end

	// ------------------------------------------------------------
	// Start pulse generator
	// ------------------------------------------------------------
	logic [15:0] pos_r, pos_nxt;
	logic [15:0] per_r, per_nxt, high_r, high_nxt;
	logic [15:0] high_req, per_req;
	logic st_r, st_nxt, full_r, full_nxt, adj_r, adj_nxt;

	// Settings are clamped and taken only at a period boundary;
	// the start pin moves on sensor clock falls, clear of rises
	always_comb begin
		high_req = at_least(HIGH_I, MIN_HIGH); // RL2
		per_req = at_least(PERIOD_I, high_req + MIN_LOW); // RL3
		per_req = at_least(per_req, MIN_PER); // RL1
		pos_nxt = pos_r;
		per_nxt = per_r;
		high_nxt = high_r;
		st_nxt = st_r;
		full_nxt = full_r;
		adj_nxt = adj_r;
		if (sclk_fall) begin
			// Stopping waits for a boundary, so no pulse is cut short
			if (pos_r == 16'h0000 || pos_r >= per_r) begin
				if (RUN_I) begin
					pos_nxt = 16'h0001;
					per_nxt = per_req;
					high_nxt = high_req; // RL6
					st_nxt = 1'b1;
					full_nxt = (per_req >= FULL_PER); // RL10
					adj_nxt = (per_req != PERIOD_I) || (high_req != HIGH_I);
				end else begin
					pos_nxt = 16'h0000;
					st_nxt = 1'b0;
				end
			end else begin
				pos_nxt = pos_r + 16'h0001;
				st_nxt = (pos_r < high_r); // RL12
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pos_r <= 16'h0000;
			per_r <= scan_pkg::RST_PERIOD;
			high_r <= scan_pkg::RST_HIGH;
			st_r <= 1'b0;
			full_r <= 1'b0;
			adj_r <= 1'b0;
		end else begin
			pos_r <= pos_nxt;
			per_r <= per_nxt;
			high_r <= high_nxt;
			st_r <= st_nxt;
			full_r <= full_nxt;
			adj_r <= adj_nxt;
		end
	end

	// ------------------------------------------------------------
	// Strobe counting and pixel capture
	// ------------------------------------------------------------
	logic trig_q_r, eos_q_r, arm_r, arm_nxt, cnt_ok_r, cnt_ok_nxt;
	logic [15:0] strobe_r, strobe_nxt;
	logic vld_r, vld_nxt, done_r, done_nxt;
	logic [PIX_W-1:0] data_r, data_nxt;
	logic [15:0] idx_r, idx_nxt;
	logic trig_up, st_fell;

	assign trig_up = LINK.trig & ~trig_q_r;
	assign st_fell = sclk_fall & st_r & ~st_nxt;

	// Count strobes from the first clock rise after start falls;
	// strobes already in flight at the fall are left out
	always_comb begin
		arm_nxt = arm_r;
		cnt_ok_nxt = cnt_ok_r;
		strobe_nxt = strobe_r;
		vld_nxt = 1'b0;
		data_nxt = data_r;
		idx_nxt = idx_r;
		done_nxt = LINK.scan_done_flag & ~eos_q_r; // RL15
		if (st_fell) begin
			arm_nxt = 1'b1;
			cnt_ok_nxt = 1'b0;
		end else if (arm_r && sclk_rise) begin
			arm_nxt = 1'b0; // RL4
			cnt_ok_nxt = 1'b1;
			strobe_nxt = 16'h0000;
		end else if (trig_up && cnt_ok_r) begin
			strobe_nxt = strobe_r + 16'h0001;
			if (strobe_nxt >= FIRST_S &&
				strobe_nxt - FIRST_S < NPIX) begin // RL7
				vld_nxt = 1'b1;
				data_nxt = LINK.video; // RL8
				idx_nxt = strobe_nxt - FIRST_S;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			trig_q_r <= 1'b0;
			eos_q_r <= 1'b0;
			arm_r <= 1'b0;
			cnt_ok_r <= 1'b0;
			strobe_r <= 16'h0000;
			vld_r <= 1'b0;
			data_r <= '0;
			idx_r <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			trig_q_r <= LINK.trig;
			eos_q_r <= LINK.scan_done_flag;
			arm_r <= arm_nxt;
			cnt_ok_r <= cnt_ok_nxt;
			strobe_r <= strobe_nxt;
			vld_r <= vld_nxt;
			data_r <= data_nxt;
			idx_r <= idx_nxt;
			done_r <= done_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign LINK.sclk = sclk_r;
	assign LINK.scan_start_pulse = st_r; // RL13
	assign PIX_VALID_O = vld_r;
	assign PIX_DATA_O = data_r;
	assign PIX_INDEX_O = idx_r;
	assign FRAME_DONE_O = done_r;
	assign FULL_SCAN_O = full_r;
	assign ADJUSTED_O = adj_r;
endmodule

// File: test/linear_sensor_scan_timing_properties.sv
`timescale 1ns/1ps

// Watches the link between the sensor end and the controller end
module linear_sensor_scan_timing_properties #(
	parameter int NUM_PIX = scan_pkg::NUM_PIXELS,
	parameter int DIV = scan_pkg::SENSOR_DIV
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Link signals
	input wire logic sclk,
	input wire logic scan_start_pulse,
	input wire logic [scan_pkg::PIX_WIDTH-1:0] video,
	input wire logic trig,
	input wire logic scan_done_flag
);
	localparam int HALF = DIV / 2;
	localparam int LEAD = scan_pkg::FIRST_VALID_STROBE - 1;
	localparam int LAST_TRIG = LEAD + NUM_PIX;
	localparam int HIGH_MIN = scan_pkg::MIN_HIGH_CLK * DIV;
	localparam int LOW_MIN = scan_pkg::MIN_LOW_CLK * DIV;
	localparam int PER_MIN = scan_pkg::MIN_PERIOD_CLK * DIV;
	localparam int TRIG_MAX = 3 * DIV;

	logic st_q_r, st_q_nxt, tr_q_r, tr_q_nxt;
	logic seen_fall_r, seen_fall_nxt, seen_rise_r, seen_rise_nxt;
	logic [15:0] high_r, high_nxt, low_r, low_nxt, per_r, per_nxt;
	logic [15:0] trig_cnt_r, trig_cnt_nxt;
	logic in_scan;

	default clocking dclk @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);

	// Pulse lengths, and strobes counted once the start pulse has fallen
	always_comb begin
		in_scan = scan_start_pulse || low_r > 16'h0001;
		st_q_nxt = scan_start_pulse;
		tr_q_nxt = trig;
		high_nxt = scan_start_pulse ? high_r + 16'h0001 : 16'h0000;
		low_nxt = scan_start_pulse ? 16'h0000 : low_r + 16'h0001;
		per_nxt = (scan_start_pulse && !st_q_r) ? 16'h0001 : per_r + 16'h0001;
		seen_fall_nxt = seen_fall_r | (st_q_r & ~scan_start_pulse);
		seen_rise_nxt = seen_rise_r | (scan_start_pulse & ~st_q_r);
		trig_cnt_nxt = trig_cnt_r;
		// Readout may run on into the next high phase
		if (st_q_r && !scan_start_pulse) begin
			trig_cnt_nxt = 16'h0000;
		end else if (trig && !tr_q_r && in_scan) begin
			trig_cnt_nxt = trig_cnt_r + 16'h0001; // Skips strobes in flight
		end
	end

	// Helper registers
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q_r <= 1'b0;
			tr_q_r <= 1'b0;
			seen_fall_r <= 1'b0;
			seen_rise_r <= 1'b0;
			high_r <= 16'h0000;
			low_r <= 16'h0000;
			per_r <= 16'h0000;
			trig_cnt_r <= 16'h0000;
		end else begin
			st_q_r <= st_q_nxt;
			tr_q_r <= tr_q_nxt;
			seen_fall_r <= seen_fall_nxt;
			seen_rise_r <= seen_rise_nxt;
			high_r <= high_nxt;
			low_r <= low_nxt;
			per_r <= per_nxt;
			trig_cnt_r <= trig_cnt_nxt;
		end
	end

	a_start_period_min: assert property (
		$rose(scan_start_pulse) && seen_rise_r |-> per_r >= PER_MIN)
		else $error("start period too short");
	a_start_high_min: assert property (
		$fell(scan_start_pulse) |-> high_r >= HIGH_MIN)
		else $error("start high time too short");
	a_start_low_min: assert property (
		$rose(scan_start_pulse) && seen_fall_r |-> low_r >= LOW_MIN)
		else $error("start low time too short");
	a_first_strobe: assert property (
		$fell(scan_start_pulse) |-> ##[1:TRIG_MAX] $rose(trig))
		else $error("no strobe after start fall");
	a_video_dark_lead: assert property (
		$rose(trig) && in_scan && trig_cnt_r < LEAD |-> video == '0)
		else $error("video not dark before first valid strobe");
	a_strobe_half: assert property (
		$rose(trig) |-> ##HALF $fell(trig))
		else $error("strobe high time wrong");
	a_clock_square: assert property (
		$rose(sclk) |-> ##HALF $fell(sclk))
		else $error("sensor clock not square");
	a_strobe_rate: assert property (
		$rose(trig) && in_scan &&
		trig_cnt_r < LAST_TRIG - 1 |-> ##DIV $rose(trig))
		else $error("strobe not once per sensor clock");
	a_done_after_last: assert property (
		$rose(scan_done_flag) |-> trig_cnt_r == LAST_TRIG)
		else $error("scan done not after last pixel");
	a_done_one_clock: assert property (
		$rose(scan_done_flag) |-> ##DIV $fell(scan_done_flag))
		else $error("scan done width wrong");
endmodule

// File: test/linear_sensor_scan_timing_tb.sv
`timescale 1ns/1ps

// Both ends joined by the link, driven from their user sides
module linear_sensor_scan_timing_tb;
	localparam int NPIX = 16;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic [15:0] period = 16'h00c8;
	logic [15:0] high = 16'h000a;
	logic [11:0] illum = 12'h000;
	logic pix_valid, frame_done, full_scan, adjusted, integ;
	logic [11:0] pix_data;
	logic [15:0] pix_index, exposure;
	logic [31:0] rnd = 32'h48afce33;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	int p, h;

	sensor_link_if sensor_link_if_i ();
	scan_controller_end #(.NUM_PIX(NPIX)) scan_controller_end_i (
		.SYS_CLK_I(sys_clk), .RST_I(rst), .LINK(sensor_link_if_i),
		.RUN_I(run), .PERIOD_I(period), .HIGH_I(high),
		.PIX_VALID_O(pix_valid), .PIX_DATA_O(pix_data),
		.PIX_INDEX_O(pix_index), .FRAME_DONE_O(frame_done),
		.FULL_SCAN_O(full_scan), .ADJUSTED_O(adjusted));
	line_sensor_end #(.NUM_PIX(NPIX)) line_sensor_end_i (
		.SYS_CLK_I(sys_clk), .RST_I(rst), .LINK(sensor_link_if_i),
		.ILLUM_I(illum), .INTEG_O(integ), .EXPOSURE_CLK_O(exposure));
	linear_sensor_scan_timing_properties #(.NUM_PIX(NPIX)) link_checker_i (
		.SYS_CLK_I(sys_clk), .RST_I(rst), .sclk(sensor_link_if_i.sclk),
		.scan_start_pulse(sensor_link_if_i.scan_start_pulse),
		.video(sensor_link_if_i.video), .trig(sensor_link_if_i.trig),
		.scan_done_flag(sensor_link_if_i.scan_done_flag));

	// Clock and hang guard
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Shared well level: light times clocks, saturating at full scale
	function automatic logic [15:0] sat(input logic [11:0] lum, input int k);
		int v;
		v = int'(lum) * k;
		return (v > 4095) ? 16'h0fff : v[15:0];
	endfunction

	task automatic check(input string what, input logic [15:0] lo,
		input logic [15:0] hi, input logic [15:0] got);
		samples_checked++;
		if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo,
				hi, got);
		end
	endtask

	task automatic wait_frame();
		int t;
		t = 0;
		do begin
			@(negedge sys_clk);
			t++;
		end while (frame_done !== 1'b1 && t < 40000);
		check("frame done", 16'h0001, 16'h0001, {15'h0000, frame_done});
	endtask

	// Applies one setting, waits nwait frames, then checks one whole frame; with nwait 0 it checks only the adjusted flag
	task automatic run_config(input logic [15:0] per, input logic [15:0] hi,
		input logic [11:0] lum, input int nwait);
		int eh, ep, n;
		logic [15:0] adj, first;
		eh = (hi < scan_pkg::MIN_HIGH_CLK) ? scan_pkg::MIN_HIGH_CLK : hi;
		ep = (per < eh + scan_pkg::MIN_LOW_CLK) ? eh + scan_pkg::MIN_LOW_CLK : per;
		ep = (ep < scan_pkg::MIN_PERIOD_CLK) ? scan_pkg::MIN_PERIOD_CLK : ep;
		adj = {15'h0000, (eh != hi || ep != per)};
		first = 16'h0000;
		@(posedge sys_clk);
		period <= per;
		high <= hi;
		illum <= lum;
		if (nwait == 0) begin
			repeat (16 * ep) @(posedge sys_clk);
			check("adjusted", adj, adj, {15'h0000, adjusted});
			return;
		end
		repeat (nwait) wait_frame();
		check("adjusted", adj, adj, {15'h0000, adjusted});
		check("full scan", 16'(ep >= scan_pkg::FULL_SCAN_CLK),
			16'(ep >= scan_pkg::FULL_SCAN_CLK), {15'h0000, full_scan});
		check("exposure", 16'(eh + 47), 16'(eh + 49), exposure);
		n = 0;
		do begin
			@(negedge sys_clk);
			if (pix_valid === 1'b1) begin
				if (n == 0) begin
					first = {4'h0, pix_data};
					check("integrating", 16'h0000, 16'h0000,
						{15'h0000, integ});
				end
				check("pixel index", 16'(n), 16'(n), pix_index);
				check("pixel level", first, first, {4'h0, pix_data});
				n++;
			end
		end while (frame_done !== 1'b1 && n <= NPIX);
		check("pixel count", 16'(NPIX), 16'(NPIX), 16'(n));
		check("frame level", sat(lum, eh + 47), sat(lum, eh + 49), first);
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence: corner settings, random settings, reset, full scan
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		run <= 1'b1;
		run_config(16'h00c8, 16'h000a, 12'h064, 3);
		run_config(16'h0078, 16'h001c, 12'hfff, 3);
		run_config(16'h0190, 16'h012c, 12'h000, 3);
		run_config(16'h0064, 16'h003c, 12'h021, 3);
		run_config(16'h0032, 16'h0003, 12'h010, 0);
		repeat (3) begin
			repeat (8) rnd = lfsr(rnd);
			p = 120 + int'(rnd[7:0]);
			h = 6 + int'(rnd[23:16]) % (p - 97);
			run_config(16'(p), 16'(h), {4'h0, rnd[31:24]}, 3);
		end
		// Stop request takes effect at the next period boundary
		@(posedge sys_clk);
		run <= 1'b0;
		repeat (3000) @(posedge sys_clk);
		@(negedge sys_clk);
		check("start held low", 16'h0000, 16'h0000,
			{15'h0000, sensor_link_if_i.scan_start_pulse});
		@(posedge sys_clk);
		period <= 16'h085c;
		high <= 16'h0800;
		rst <= 1'b1;
		run <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		run_config(16'h085c, 16'h0800, 12'h001, 1);
		end_of_test();
	end
endmodule
